// File: verilog/bscrc_pkg.sv
// constants shared by the bus-snoop crc engine and its testbench
package bscrc_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_RESULT  = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_CONFIG  = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;

  // control register fields
  localparam int CTL_CLEAR_BIT = 0;
  localparam int CTL_HOLD_BIT  = 1;

  // status register fields
  localparam int STA_BUSY_BIT  = 0;
  localparam int STA_STALL_BIT = 1;
  localparam int STA_LVL_LSB   = 8;

  // polynomial select codes held in the config register
  typedef enum logic [1:0] {
    BSCRC_SEL_CRC8   = 2'h0,
    BSCRC_SEL_CRC16A = 2'h1,
    BSCRC_SEL_CRC16B = 2'h2,
    BSCRC_SEL_CRC32  = 2'h3
  } bscrc_sel_e;

  // generator polynomials, msb-first, implicit top term dropped
  localparam logic [31:0] POLY_CRC8   = 32'h0000_0007;
  localparam logic [31:0] POLY_CRC16A = 32'h0000_8005;
  localparam logic [31:0] POLY_CRC16B = 32'h0000_1021;
  localparam logic [31:0] POLY_CRC32  = 32'h04c1_1db7;

  // reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [1:0]  CONFIG_RST = 2'h0;

  // access size code of a byte read on a snooped bus
  localparam logic [1:0] SIZE_BYTE = 2'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: verilog/bscrc_fifo.sv
// byte buffer between the bus snoopers and the crc datapath
`timescale 1ns/1ps
`default_nettype none
module bscrc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign level     = cnt_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers wrap on depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule
`default_nettype wire

// File: verilog/bscrc_engine.sv
// bus-snooping crc engine with security gating and axi4-lite registers
//
// Operation
// - snoop reads on both the code-space data bus and the system bus
// - capture only reads whose address lies in the mirrored alias region
// - update result after each captured byte; software may read it anytime
// - only byte-sized reads feed the crc
// - half-word and word mirrored reads are dropped, result unchanged
// - debugger-issued mirrored reads never reach the crc
// - support crc8 poly 0x07 and crc32 poly 0x04c11db7
// - support two crc16 polys, 0x8005 and 0x1021
// - writing 1 to control clear field zeroes the result
// - config register selects one of the four polynomials
// - software may write the result register to restore a saved crc
// - code in one zone cannot crc memory of another secure zone
// - same-zone reads of execute-only sectors feed crc, cpu gets nothing
// - blocked secure reads return zero without stalling the cpu
// - secure zone with pc inside it blocks only debug accesses
// - secure zone with pc outside it blocks every access
`timescale 1ns/1ps
`default_nettype none
module bscrc_engine #(
  parameter int          NBUS        = 2,
  parameter int          FIFO_DEPTH  = 16,
  parameter logic [31:0] MIRROR_MASK = 32'hf000_0000,
  parameter logic [31:0] MIRROR_BASE = 32'h1000_0000
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // axi4-lite register slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // snooped reads, bus 0 code_space_data_bus, bus 1 system bus
  input  wire logic [NBUS-1:0]      snoop_rd_valid,
  input  wire logic [NBUS*32-1:0]   snoop_rd_addr,
  input  wire logic [NBUS*2-1:0]    snoop_rd_size,
  input  wire logic [NBUS*32-1:0]   snoop_rd_data,
  input  wire logic [NBUS-1:0]      snoop_rd_debug,
  input  wire logic [NBUS*2-1:0]    snoop_rd_zone,
  input  wire logic [NBUS-1:0]      snoop_rd_exeonly,
  // memory_access_guard state
  input  wire logic [1:0]           zone_secure,
  input  wire logic [1:0]           pc_zone,
  // gated read data returned to the processor
  output logic [NBUS-1:0]           cpu_ret_valid,
  output logic [NBUS*32-1:0]        cpu_ret_data,
  output logic                      snoop_stall
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  logic [NBUS-1:0]   cap_v;
  logic [NBUS*8-1:0] cap_b;
  logic [NBUS-1:0]   deny;
  logic [NBUS-1:0]   pend_v_r;
  logic [NBUS-1:0]   pend_v_nxt;
  logic [NBUS*8-1:0] pend_b_r;
  logic [NBUS-1:0]   push_one;
  logic              stall_r;
  logic              f_in_valid;
  logic              f_in_ready;
  logic [7:0]        f_in_data;
  logic              f_out_valid;
  logic              f_out_ready;
  logic [7:0]        f_out_data;
  logic [LW-1:0]     f_level;
  logic [31:0]       crc_result_reg;
  logic [1:0]        crc_config_reg;
  logic              hold_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic              ar_full_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic [7:0]        ar_addr_r;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_do;
  logic              rd_do;
  logic              busy;
  logic              sw_res_wr;
  logic              sw_clear;
  logic [31:0]       wmask;

  // crc mask for the selected width
  function automatic logic [31:0] crc_mask(input logic [1:0] sel);
    unique case (bscrc_pkg::bscrc_sel_e'(sel))
      bscrc_pkg::BSCRC_SEL_CRC8:   crc_mask = 32'h0000_00ff;
      bscrc_pkg::BSCRC_SEL_CRC16A: crc_mask = 32'h0000_ffff;
      bscrc_pkg::BSCRC_SEL_CRC16B: crc_mask = 32'h0000_ffff;
      bscrc_pkg::BSCRC_SEL_CRC32:  crc_mask = 32'hffff_ffff;
    endcase
  endfunction

  // one byte folded msb-first into the running remainder
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  b,
                                           input logic [1:0]  sel);
    logic [31:0] r;
    logic [31:0] p;
    logic [4:0]  top;
    logic        fb;
    r   = c & crc_mask(sel);
    p   = bscrc_pkg::POLY_CRC32;
    top = 5'd31;
    unique case (bscrc_pkg::bscrc_sel_e'(sel))
      bscrc_pkg::BSCRC_SEL_CRC8: begin
        p   = bscrc_pkg::POLY_CRC8;
        top = 5'd7;
      end
      bscrc_pkg::BSCRC_SEL_CRC16A: begin
        p   = bscrc_pkg::POLY_CRC16A;
        top = 5'd15;
      end
      bscrc_pkg::BSCRC_SEL_CRC16B: begin
        p   = bscrc_pkg::POLY_CRC16B;
        top = 5'd15;
      end
      bscrc_pkg::BSCRC_SEL_CRC32: begin
        p   = bscrc_pkg::POLY_CRC32;
        top = 5'd31;
      end
    endcase
    for (int i = 0; i < 8; i++) begin
      fb = r[top] ^ b[3'(7 - i)];
      r  = (r << 1) & crc_mask(sel);
      if (fb) begin
        r = r ^ p;
      end
    end
    crc_step = r;
  endfunction

  // per-bus security gating, capture decision and processor return path
  generate
    for (genvar g = 0; g < NBUS; g++) begin : g_bus
      logic [31:0] addr;
      logic [1:0]  zone;
      logic        mirror;
      assign addr   = snoop_rd_addr[g*32 +: 32];
      assign zone   = snoop_rd_zone[g*2 +: 2];
      assign mirror = ((addr & MIRROR_MASK) == MIRROR_BASE);
      // a zone code of zero marks unsecured memory
      assign deny[g] = ((zone == 2'h1 && zone_secure[0]) || (zone == 2'h2 && zone_secure[1]))
                       && (snoop_rd_debug[g]
                           || (pc_zone != zone));
      assign cap_v[g] = snoop_rd_valid[g] & mirror & ~deny[g]
                        & (snoop_rd_size[g*2 +: 2] == bscrc_pkg::SIZE_BYTE)
                        & ~snoop_rd_debug[g] & ~stall_r;
      // byte lane picked by the low address bits
      assign cap_b[g*8 +: 8] = snoop_rd_data[g*32 + 8*addr[1:0] +: 8];

      // the processor never waits on the guard; denied data reads as zero
      always_ff @(posedge clk) begin
        if (rst) begin
          cpu_ret_valid[g]         <= 1'b0;
          cpu_ret_data[g*32 +: 32] <= 32'h0000_0000;
        end else begin
          cpu_ret_valid[g] <= snoop_rd_valid[g];
          if (deny[g] || snoop_rd_exeonly[g]) begin
            cpu_ret_data[g*32 +: 32] <= 32'h0000_0000;
          end else begin
            cpu_ret_data[g*32 +: 32] <= snoop_rd_data[g*32 +: 32];
          end
        end
      end
    end
  endgenerate

  // lowest pending bus wins the buffer; higher buses wait in their slots for a later cycle
  always_comb begin
    push_one   = '0;
    f_in_data  = pend_b_r[7:0];
    for (int i = NBUS - 1; i >= 0; i--) begin
      if (pend_v_r[i]) begin
        push_one  = '0;
        push_one[i] = 1'b1;
        f_in_data = pend_b_r[i*8 +: 8];
      end
    end
  end
  assign f_in_valid = |pend_v_r;

  // one staging slot per bus; reads offered while stalled are refused, so none is lost
  always_comb begin
    pend_v_nxt = pend_v_r;
    if (f_in_ready) begin
      pend_v_nxt = pend_v_r & ~push_one;
    end
    pend_v_nxt = pend_v_nxt | cap_v;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_v_r <= '0;
      pend_b_r <= '0;
      stall_r  <= 1'b0;
    end else begin
      pend_v_r <= pend_v_nxt;
      stall_r  <= |pend_v_nxt;
      for (int i = 0; i < NBUS; i++) begin
        if (cap_v[i]) begin
          pend_b_r[i*8 +: 8] <= cap_b[i*8 +: 8];
        end
      end
    end
  end
  assign snoop_stall = stall_r;

  bscrc_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // a software write to the result or to the clear field pauses the datapath for that cycle
  assign sw_res_wr = wr_do && (aw_addr_r == bscrc_pkg::OFF_RESULT);
  assign sw_clear  = wr_do && (aw_addr_r == bscrc_pkg::OFF_CONTROL)
                     && w_strb_r[0] && w_data_r[bscrc_pkg::CTL_CLEAR_BIT];
  assign f_out_ready = ~hold_r & ~sw_res_wr & ~sw_clear;
  assign busy        = f_out_valid | (|pend_v_r);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb_r[i]}};
    end
  end

  // result register: clear, restore or fold one byte per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_result_reg <= bscrc_pkg::RESULT_RST;
    end else if (sw_clear) begin
      crc_result_reg <= bscrc_pkg::RESULT_RST;
    end else if (sw_res_wr) begin
      crc_result_reg <= ((crc_result_reg & ~wmask) | (w_data_r & wmask))
                        & crc_mask(crc_config_reg);
    end else if (f_out_valid && f_out_ready) begin
      crc_result_reg <= crc_step(crc_result_reg, f_out_data,
                                 crc_config_reg);
    end
  end

  // config and hold are plain software state
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_config_reg <= bscrc_pkg::CONFIG_RST;
      hold_r         <= 1'b0;
    end else if (wr_do && w_strb_r[0]) begin
      if (aw_addr_r == bscrc_pkg::OFF_CONFIG) begin
        crc_config_reg <= w_data_r[1:0];
      end
      if (aw_addr_r == bscrc_pkg::OFF_CONTROL) begin
        hold_r <= w_data_r[bscrc_pkg::CTL_HOLD_BIT];
      end
    end
  end

  // write channels are taken independently and joined before the response
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_do   = aw_full_r & w_full_r & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      aw_full_r     <= (aw_full_r | aw_take) & ~wr_do;
      w_full_r      <= (w_full_r | w_take) & ~wr_do;
      s_axi_awready <= ~((aw_full_r | aw_take) & ~wr_do);
      s_axi_wready  <= ~((w_full_r | w_take) & ~wr_do);
      if (aw_take) begin
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // write response, error for offsets outside the map or read-only status
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bscrc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_r == bscrc_pkg::OFF_RESULT || aw_addr_r == bscrc_pkg::OFF_CONTROL
          || aw_addr_r == bscrc_pkg::OFF_CONFIG) begin
        s_axi_bresp <= bscrc_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= bscrc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // a result read waits for buffered bytes, unless hold is set, so it covers every earlier read
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_do   = ar_full_r & ~s_axi_rvalid
                   & ((ar_addr_r != bscrc_pkg::OFF_RESULT) | ~busy | hold_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      ar_full_r     <= 1'b0;
      s_axi_arready <= 1'b0;
      ar_addr_r     <= 8'h00;
    end else begin
      ar_full_r     <= (ar_full_r | ar_take) & ~rd_do;
      s_axi_arready <= ~((ar_full_r | ar_take) & ~rd_do);
      if (ar_take) begin
        ar_addr_r <= {s_axi_araddr[7:2], 2'b00};
      end
    end
  end

  // read data mux; unused bits and the status gaps read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bscrc_pkg::RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= bscrc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (ar_addr_r == bscrc_pkg::OFF_RESULT) begin
        s_axi_rdata <= crc_result_reg & crc_mask(crc_config_reg);
      end else if (ar_addr_r == bscrc_pkg::OFF_CONTROL) begin
        s_axi_rdata[bscrc_pkg::CTL_HOLD_BIT] <= hold_r;
      end else if (ar_addr_r == bscrc_pkg::OFF_CONFIG) begin
        s_axi_rdata[1:0] <= crc_config_reg;
      end else if (ar_addr_r == bscrc_pkg::OFF_STATUS) begin
        s_axi_rdata[bscrc_pkg::STA_BUSY_BIT]  <= busy;
        s_axi_rdata[bscrc_pkg::STA_STALL_BIT] <= stall_r;
        s_axi_rdata[bscrc_pkg::STA_LVL_LSB +: LW] <= f_level;
      end else begin
        s_axi_rresp <= bscrc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: verif/bscrc_engine_assertions.sv
// concurrent checks on the ports of the bus-snoop crc engine
`timescale 1ns/1ps
`default_nettype none
module bscrc_engine_assertions #(
  parameter int NBUS = 2
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               s_axi_awvalid,
  input  wire logic               s_axi_awready,
  input  wire logic               s_axi_wvalid,
  input  wire logic               s_axi_wready,
  input  wire logic               s_axi_bvalid,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  input  wire logic               s_axi_arready,
  input  wire logic               s_axi_rvalid,
  input  wire logic [NBUS-1:0]    snoop_rd_valid,
  input  wire logic [NBUS*32-1:0] snoop_rd_data,
  input  wire logic [NBUS-1:0]    snoop_rd_debug,
  input  wire logic [NBUS*2-1:0]  snoop_rd_zone,
  input  wire logic [NBUS-1:0]    snoop_rd_exeonly,
  input  wire logic [1:0]         zone_secure,
  input  wire logic [1:0]         pc_zone,
  input  wire logic [NBUS-1:0]    cpu_ret_valid,
  input  wire logic [NBUS*32-1:0] cpu_ret_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // bus 0 target sits in a zone that is secure right now
  wire logic [1:0]  z0      = snoop_rd_zone[1:0];
  wire logic [31:0] r0      = cpu_ret_data[31:0];
  wire logic        sec0    = (z0 == 2'h1 && zone_secure[0]) || (z0 == 2'h2 && zone_secure[1]);
  wire logic        deny0   = sec0 && (snoop_rd_debug[0] || pc_zone != z0);
  wire logic        pass0   = snoop_rd_valid[0] && !deny0 && !snoop_rd_exeonly[0];
  wire logic        wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic        ar_reg  = s_axi_arvalid && s_axi_arready && s_axi_araddr != bscrc_pkg::OFF_RESULT;

  AST_RET_TRACKS: assert property (cpu_ret_valid == $past(snoop_rd_valid))
    else $error("returned read strobe does not follow the snooped read");
  AST_PC_OUT_BLOCK: assert property (snoop_rd_valid[0] && sec0 && pc_zone != z0 |=> r0 == 32'h0)
    else $error("read from outside a secure zone leaked data");
  AST_DBG_BLOCK: assert property (snoop_rd_valid[0] && sec0 && snoop_rd_debug[0] |=> r0 == 32'h0)
    else $error("debug read of a secure zone leaked data");
  AST_EXE_HIDDEN: assert property (snoop_rd_valid[0] && snoop_rd_exeonly[0] |=> r0 == 32'h0)
    else $error("execute-only data reached the processor");
  AST_PASS: assert property (pass0 |=> r0 == $past(snoop_rd_data[31:0]))
    else $error("permitted read did not return its data");
  AST_B_ANSWER: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_ANSWER: assert property (ar_reg |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address slot reopened while a write is held");
endmodule
bind bscrc_engine bscrc_engine_assertions #(.NBUS(NBUS)) chk_u (.*);
`default_nettype wire

// File: verif/bscrc_host_model.sv
// processor bus model that issues the reads the engine snoops
`timescale 1ns/1ps
`default_nettype none
module bscrc_host_model #(
  parameter int NBUS = 2
) (
  input  wire logic               clk,
  input  wire logic               snoop_stall,
  output logic [NBUS-1:0]         snoop_rd_valid,
  output logic [NBUS*32-1:0]      snoop_rd_addr,
  output logic [NBUS*2-1:0]       snoop_rd_size,
  output logic [NBUS*32-1:0]      snoop_rd_data,
  output logic [NBUS-1:0]         snoop_rd_debug,
  output logic [NBUS*2-1:0]       snoop_rd_zone,
  output logic [NBUS-1:0]         snoop_rd_exeonly
);
  // idle buses at time zero
  initial {snoop_rd_valid, snoop_rd_addr, snoop_rd_size, snoop_rd_data,
           snoop_rd_debug, snoop_rd_zone, snoop_rd_exeonly} = '0;

  // one read on bus b, held until an edge sees stall low; last releases the bus
  task automatic snp(input int b, input logic [31:0] a, input logic [1:0] sz, input logic [31:0] w,
                     input logic dbg, input logic [1:0] z, input logic x, input logic last);
    snoop_rd_valid[b] <= 1'b1;
    snoop_rd_addr[32*b +: 32] <= a;
    snoop_rd_size[2*b +: 2] <= sz;
    snoop_rd_data[32*b +: 32] <= w;
    snoop_rd_debug[b] <= dbg;
    snoop_rd_zone[2*b +: 2] <= z;
    snoop_rd_exeonly[b] <= x;
    do @(posedge clk); while (snoop_stall);
    if (last) begin
      snoop_rd_valid[b] <= 1'b0;
      snoop_rd_data[32*b +: 32] <= ~w; // released bus must not keep showing the byte
    end
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking testbench for the bus-snoop crc engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0]  A_RES = bscrc_pkg::OFF_RESULT;
  localparam logic [7:0]  A_CTL = bscrc_pkg::OFF_CONTROL;
  localparam logic [7:0]  A_CFG = bscrc_pkg::OFF_CONFIG;
  localparam logic [7:0]  A_STA = bscrc_pkg::OFF_STATUS;
  localparam logic [1:0]  OK = bscrc_pkg::RESP_OKAY;
  localparam logic [1:0]  ER = bscrc_pkg::RESP_SLVERR;
  localparam logic [31:0] MB = 32'h1000_0000;
  localparam logic [31:0] NM = 32'h2000_0000;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, snoop_stall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, zone_secure, pc_zone, snoop_rd_valid, snoop_rd_debug, snoop_rd_exeonly;
  logic [1:0]  cpu_ret_valid;
  logic [3:0]  snoop_rd_size, snoop_rd_zone;
  logic [63:0] snoop_rd_addr, snoop_rd_data, cpu_ret_data;
  int          miscompares, check_count, cycles;

  bscrc_engine #(.NBUS(2), .FIFO_DEPTH(16)) dut_u (.*);
  bscrc_host_model #(.NBUS(2)) host_u (.*);

  // clock of 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, well above the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // msb-first fold of one byte, width and polynomial from the select code
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] b, input logic [1:0] s);
    int          w;
    logic [31:0] p;
    w = (s == 2'h0) ? 8 : (s == 2'h3) ? 32 : 16;
    p = (s == 2'h0) ? bscrc_pkg::POLY_CRC8 : (s == 2'h1) ? bscrc_pkg::POLY_CRC16A :
        (s == 2'h2) ? bscrc_pkg::POLY_CRC16B : bscrc_pkg::POLY_CRC32;
    c = c ^ ({24'h0, b} << (w - 8));
    for (int i = 0; i < 8; i++) c = c[w-1] ? ((c << 1) ^ p) : (c << 1);
    return (w == 32) ? c : c & ((32'h1 << w) - 32'h1);
  endfunction

  // byte in its lane, other lanes inverted so a wrong lane shows
  function automatic logic [31:0] lane(input logic [31:0] a, input logic [7:0] b);
    logic [31:0] w;
    w = {4{~b}};
    w[8*a[1:0] +: 8] = b;
    return w;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, OK, d);
    chk(d, e);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rdc(A_RES, 32'h0);
    rdc(A_CFG, 32'h0);
    wr(8'h10, 32'h1, ER);
    rd(8'h10, ER, d);
    wr(A_STA, 32'h0, ER);
    wr(A_CFG, 32'h3, OK);
    wr(A_RES, 32'h1234_5678, OK);
    rdc(A_RES, 32'h1234_5678);
    wr(A_CFG, 32'h1, OK);
    rdc(A_RES, 32'h5678);
    wr(A_CFG, 32'h0, OK);
    rdc(A_RES, 32'h78);
  endtask

  task automatic t_poly;
    logic [31:0] e;
    logic [7:0]  b;
    for (int s = 0; s < 4; s++) begin
      wr(A_CFG, 32'(s), OK);
      wr(A_CTL, 32'h1, OK);
      e = 32'h0;
      for (int i = 0; i < 4; i++) begin
        b = 8'(8'h9d + i * 53 + s);
        host_u.snp(i % 2, MB + 32'(i), 2'h0, lane(MB + 32'(i), b), 1'b0, 2'h0, 1'b0, 1'b1);
        e = fold(e, b, 2'(s));
      end
      rdc(A_RES, e);
    end
  endtask

  task automatic t_filter;
    wr(A_CTL, 32'h1, OK);
    host_u.snp(0, NM + 32'h1, 2'h0, lane(32'h1, 8'h5a), 1'b0, 2'h0, 1'b0, 1'b0);
    host_u.snp(0, MB + 32'h2, 2'h1, lane(32'h2, 8'h5a), 1'b0, 2'h0, 1'b0, 1'b0);
    host_u.snp(0, MB, 2'h2, lane(32'h0, 8'h5a), 1'b0, 2'h0, 1'b0, 1'b0);
    host_u.snp(0, MB + 32'h3, 2'h0, lane(32'h3, 8'h5a), 1'b1, 2'h0, 1'b0, 1'b0);
    host_u.snp(0, MB + 32'h3, 2'h0, lane(32'h3, 8'h3c), 1'b0, 2'h0, 1'b0, 1'b1);
    rdc(A_RES, fold(32'h0, 8'h3c, 2'h3));
  endtask

  // rows: pc zone, debug, execute-only, data returned
  task automatic t_secure;
    logic [4:0]  row [5] = '{5'b00000, 5'b10000, 5'b01001, 5'b01100, 5'b01010};
    logic [31:0] e;
    logic [31:0] w;
    wr(A_CFG, 32'h2, OK);
    wr(A_CTL, 32'h1, OK);
    e = 32'h0;
    zone_secure <= 2'b01;
    for (int i = 0; i < 5; i++) begin
      w = lane(32'(i), 8'(8'h61 + i));
      pc_zone <= row[i][4:3];
      host_u.snp(0, MB + 32'(i), 2'h0, w, row[i][2], 2'h1, row[i][1], 1'b1);
      @(posedge clk);
      chk(cpu_ret_data[31:0], row[i][0] ? w : 32'h0);
      if (row[i][0] || row[i][1]) e = fold(e, 8'(8'h61 + i), 2'h2);
    end
    zone_secure <= 2'b00;
    pc_zone <= 2'h0;
    rdc(A_RES, e);
  endtask

  // hold folding so the buffer fills and stalls the bus, then drain it
  task automatic t_fifo;
    logic [31:0] e;
    logic [31:0] d;
    wr(A_CFG, 32'h0, OK);
    wr(A_CTL, 32'h3, OK);
    fork
      for (int i = 0; i < 20; i++)
        host_u.snp(0, MB + 32'(i), 2'h0, lane(32'(i), 8'(i * 7 + 1)), 1'b0, 2'h0, 1'b0, i == 19);
      begin
        repeat (60) @(posedge clk);
        rd(A_STA, OK, d);
        chk(32'({d[12:8], d[1]}), 32'h21);
        wr(A_CTL, 32'h0, OK);
      end
    join
    e = 32'h0;
    for (int i = 0; i < 20; i++) e = fold(e, 8'(i * 7 + 1), 2'h0);
    rdc(A_RES, e);
    rd(A_STA, OK, d);
    chk(32'(d[12:8]), 32'h0);
  endtask

  // save, nested calculation, restore, continue
  task automatic t_nest;
    logic [31:0] sv;
    wr(A_CFG, 32'h1, OK);
    wr(A_CTL, 32'h1, OK);
    host_u.snp(0, MB, 2'h0, lane(32'h0, 8'h11), 1'b0, 2'h0, 1'b0, 1'b1);
    rd(A_RES, OK, sv);
    chk(sv, fold(32'h0, 8'h11, 2'h1));
    wr(A_CTL, 32'h1, OK);
    host_u.snp(1, MB + 32'h1, 2'h0, lane(32'h1, 8'h22), 1'b0, 2'h0, 1'b0, 1'b1);
    rdc(A_RES, fold(32'h0, 8'h22, 2'h1));
    wr(A_RES, sv, OK);
    host_u.snp(0, MB + 32'h2, 2'h0, lane(32'h2, 8'h33), 1'b0, 2'h0, 1'b0, 1'b1);
    rdc(A_RES, fold(sv, 8'h33, 2'h1));
  endtask

  // reset for 12 cycles, then the scenarios
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    zone_secure = 2'h0;
    pc_zone = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_poly();
    t_filter();
    t_secure();
    t_fifo();
    t_nest();
    test_done();
  end
endmodule
`default_nettype wire
